// ===== adc_trig_regs.svh
// register offsets, field positions, reset values and codes of the trigger block
`ifndef ADC_TRIG_REGS_SVH
`define ADC_TRIG_REGS_SVH

// byte offsets on the register bus
`define OFS_REQUEST_CONTROL 12'h000
`define OFS_BUFFER_A 12'h004
`define OFS_BUFFER_B 12'h008
`define OFS_COMPARE_A 12'h00C
`define OFS_COMPARE_B 12'h010
`define OFS_IRQ_STATUS 12'h014
`define OFS_IRQ_MASK 12'h018

// request control field positions
`define CTL_XFER_LSB 0
`define CTL_XFER_MSB 1
`define CTL_UP_A_BIT 4
`define CTL_DN_A_BIT 5
`define CTL_UP_B_BIT 6
`define CTL_DN_B_BIT 7
`define CTL_FS_EN_BIT 8
`define CTL_FS_SRC_LSB 12
`define CTL_FS_SRC_MSB 16

// status and mask bit positions
`define IRQ_REQ_A_BIT 0
`define IRQ_REQ_B_BIT 1
`define IRQ_XFER_BIT 2
`define IRQ_WIDTH 3

// transfer select codes
`define XFER_NONE 2'h0
`define XFER_CREST 2'h1
`define XFER_TROUGH 2'h2
`define XFER_BOTH 2'h3

// frame sync source codes
`define FS_SRC_A 5'h09
`define FS_SRC_B 5'h0A
`define FS_SRC_AB 5'h0C

// reset values
`define CTL_RESET 32'h0000_0000
`define BUF_RESET 16'h0000
`define IRQ_MASK_RESET 3'h0

`endif

// ===== adc_trig_pkg.sv
// types shared by the trigger block modules
package adc_trig_pkg;
  // operating mode of the owning timer channel, as presented on timer_mode
  typedef enum logic [2:0] {
    MODE_NORMAL = 3'h0,
    MODE_PWM1 = 3'h1,
    MODE_RESET_SYNC = 3'h3,
    MODE_COMP1 = 3'h2,
    MODE_COMP2 = 3'h6,
    MODE_COMP3 = 3'h7,
    MODE_OTHER_A = 3'h5,
    MODE_OTHER_B = 3'h4
  } mode_t;
  typedef logic [4:0] fs_src_t;
endpackage : adc_trig_pkg

// ===== req_link_if.sv
// carries start requests and frame sync controls from the top to the sync stage
`timescale 1ns/100ps
interface req_link_if;
  logic req_a;
  logic req_b;
  logic cycle_end;
  logic fs_enable;
  logic [4:0] fs_source;
  modport src (output req_a, output req_b, output cycle_end, output fs_enable,
               output fs_source);
  modport snk (input req_a, input req_b, input cycle_end, input fs_enable,
               input fs_source);
endinterface : req_link_if

// ===== delay_compare_unit.sv
// one buffered compare channel producing a single-cycle start request
`timescale 1ns/100ps
module delay_compare_unit #(
  parameter int TW = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic buf_we,
  input wire logic [TW-1:0] buf_wdata,
  input wire logic xfer,
  input wire logic active,
  input wire logic comp_mode,
  input wire logic count_down,
  input wire logic [TW-1:0] timer_count,
  input wire logic [TW-1:0] deadtime_adjusted_limit,
  input wire logic up_en,
  input wire logic dn_en,
  output logic [TW-1:0] buf_q,
  output logic [TW-1:0] cmp_q,
  output logic req
);
  logic [TW-1:0] buf_r, buf_nxt, cmp_r, cmp_nxt;
  logic hit_r, hit_nxt, req_r, req_nxt;
  logic in_up, in_dn;

  // next values; a write landing with a transfer still copies the old buffer
  always_comb begin
    buf_nxt = buf_we ? buf_wdata : buf_r;
    cmp_nxt = xfer ? buf_r : cmp_r;
    // complementary counting periods bound by the adjusted limit
    in_up = comp_mode ? (!count_down && timer_count < deadtime_adjusted_limit) : 1'b1;
    in_dn = comp_mode && count_down && timer_count != '0 &&
            timer_count <= deadtime_adjusted_limit;
    hit_nxt = active && timer_count == cmp_r &&
              ((in_up && up_en) || (in_dn && dn_en));
    // edge of the qualified match, so a held count gives one request only
    req_nxt = hit_nxt && !hit_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_r <= '0;
      cmp_r <= '0;
      hit_r <= 1'b0;
      req_r <= 1'b0;
    end else begin
      buf_r <= buf_nxt;
      cmp_r <= cmp_nxt;
      hit_r <= hit_nxt;
      req_r <= req_nxt;
    end
  end

  assign buf_q = buf_r;
  assign cmp_q = cmp_r;
  assign req = req_r;
endmodule : delay_compare_unit

// ===== frame_sync_stage.sv
// frame sync pin: high from a selected request until the end of the count cycle
`timescale 1ns/100ps
module frame_sync_stage (
  input wire logic pclk,
  input wire logic presetn,
  req_link_if.snk link,
  output logic frame_sync_pin
);
  `include "adc_trig_regs.svh"
  logic pin_r, pin_nxt, sel;

  // source pick; unlisted codes watch nothing
  always_comb begin
    case (link.fs_source)
      `FS_SRC_A: sel = link.req_a;
      `FS_SRC_B: sel = link.req_b;
      `FS_SRC_AB: sel = link.req_a | link.req_b;
      default: sel = 1'b0;
    endcase
    // a request in the cycle-end cycle keeps the pin high
    if (link.fs_enable && sel) begin
      pin_nxt = 1'b1;
    end else if (link.cycle_end || !link.fs_enable) begin
      pin_nxt = 1'b0;
    end else begin
      pin_nxt = pin_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_r <= 1'b0;
    end else begin
      pin_r <= pin_nxt;
    end
  end

  assign frame_sync_pin = pin_r;
endmodule : frame_sync_stage

// ===== adc_trigger_delay_compare.sv
// start-request generator with two buffered delay compares and an apb slave
`timescale 1ns/100ps
`include "adc_trig_regs.svh"

// Functional notes
// - two independent compares, each its own request
// - logic present only on channels four, seven
// - active only in listed timer modes
// - requests gated per count direction
// - shared transfer point: crest, trough, both
// - software writes buffer; transfer copies it
// - count equal to compare issues request
// - complementary up period is zero..limit minus one
// - complementary down period is limit..one
// - compare d rewrite also transfers buffers in complementary mode
// - frame sync high on request, low cycle end
// - four direction enables gate A and B
// - transfer select codes, 10/11 only complementary
// - five-bit code picks frame sync source
module adc_trigger_delay_compare #(
  parameter int TW = 16,
  parameter int CHANNEL = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire adc_trig_pkg::mode_t timer_mode,
  input wire logic [TW-1:0] timer_count,
  input wire logic count_down,
  input wire logic [TW-1:0] deadtime_adjusted_limit,
  input wire logic count_crest,
  input wire logic count_trough,
  input wire logic general_compare_a_match,
  input wire logic general_compare_d_write,
  input wire logic cycle_end,
  output logic adc_start_request_a,
  output logic adc_start_request_b,
  output logic adc_start_request_a_or_b,
  output logic frame_sync_pin,
  output logic irq
);
  import adc_trig_pkg::*;

  // channel presence fixed at build time
  localparam logic HAS_DELAY = (CHANNEL == 4) || (CHANNEL == 7);

  logic [31:0] ctl_r, ctl_nxt;
  logic [`IRQ_WIDTH-1:0] sts_r, sts_nxt, mask_r, mask_nxt;
  logic [31:0] rdata_nxt;
  logic wr_acc, rd_acc, mapped;
  logic comp_mode, active, xfer;
  logic [1:0] xfer_sel;
  logic req_a, req_b;
  logic [TW-1:0] buf_a, buf_b, cmp_a, cmp_b;
  logic [`IRQ_WIDTH-1:0] sts_set;
  req_link_if link ();

  // access phase decode; zero wait states so every access completes at once
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign pready = 1'b1;

  // address map check; anything else answers with an error
  always_comb begin
    case (paddr)
      `OFS_REQUEST_CONTROL,
      `OFS_BUFFER_A,
      `OFS_BUFFER_B,
      `OFS_COMPARE_A,
      `OFS_COMPARE_B,
      `OFS_IRQ_STATUS,
      `OFS_IRQ_MASK: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !mapped;

  // mode decode of the owning channel
  always_comb begin
    case (timer_mode)
      MODE_COMP1,
      MODE_COMP2,
      MODE_COMP3: begin
        comp_mode = 1'b1;
        active = HAS_DELAY;
      end
      MODE_RESET_SYNC,
      MODE_PWM1,
      MODE_NORMAL: begin
        comp_mode = 1'b0;
        active = HAS_DELAY;
      end
      default: begin
        comp_mode = 1'b0;
        active = 1'b0;
      end
    endcase
  end

  // common transfer point for both compares
  assign xfer_sel = ctl_r[`CTL_XFER_MSB:`CTL_XFER_LSB];
  always_comb begin
    xfer = 1'b0;
    if (active) begin
      if (comp_mode) begin
        case (xfer_sel)
          `XFER_CREST: xfer = count_crest;
          `XFER_TROUGH: xfer = count_trough;
          `XFER_BOTH: xfer = count_crest | count_trough;
          default: xfer = 1'b0;
        endcase
        // compare d rewrite copies the buffers regardless of the select
        xfer = xfer | general_compare_d_write;
      end else begin
        // prohibited codes outside complementary mode do nothing
        xfer = (xfer_sel == `XFER_CREST) && general_compare_a_match;
      end
    end
  end

  // control and mask registers; the down enables are stored as written,
  // and each unit's dn_en is gated by comp_mode, so they act only in complementary mode
  always_comb begin
    ctl_nxt = ctl_r;
    mask_nxt = mask_r;
    if (wr_acc && paddr == `OFS_REQUEST_CONTROL) begin
      ctl_nxt = 32'h0000_0000;
      ctl_nxt[`CTL_XFER_MSB:`CTL_XFER_LSB] = pwdata[`CTL_XFER_MSB:`CTL_XFER_LSB];
      ctl_nxt[`CTL_UP_A_BIT] = pwdata[`CTL_UP_A_BIT];
      ctl_nxt[`CTL_DN_A_BIT] = pwdata[`CTL_DN_A_BIT];
      ctl_nxt[`CTL_UP_B_BIT] = pwdata[`CTL_UP_B_BIT];
      ctl_nxt[`CTL_DN_B_BIT] = pwdata[`CTL_DN_B_BIT];
      ctl_nxt[`CTL_FS_EN_BIT] = pwdata[`CTL_FS_EN_BIT];
      ctl_nxt[`CTL_FS_SRC_MSB:`CTL_FS_SRC_LSB] = pwdata[`CTL_FS_SRC_MSB:`CTL_FS_SRC_LSB];
    end
    if (wr_acc && paddr == `OFS_IRQ_MASK) begin
      mask_nxt = pwdata[`IRQ_WIDTH-1:0];
    end
  end

  // sticky events; a new event beats the clear of a status read, and the
  // read clears only the bits it reported, since prdata was loaded in setup
  // and an event landing at that edge would otherwise be lost unseen
  assign sts_set = {xfer, req_b, req_a};
  always_comb begin
    sts_nxt = sts_r;
    if (rd_acc && paddr == `OFS_IRQ_STATUS) begin
      sts_nxt = sts_r & ~prdata[`IRQ_WIDTH-1:0];
    end
    sts_nxt = sts_nxt | sts_set;
  end

  // read mux, registered so prdata comes from flip-flops; it is loaded at the edge
  // ending the setup cycle and valid in the access cycle, since the address is stable in setup
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (psel && !pwrite) begin
      case (paddr)
        `OFS_REQUEST_CONTROL: rdata_nxt = ctl_r;
        `OFS_BUFFER_A: rdata_nxt[TW-1:0] = buf_a;
        `OFS_BUFFER_B: rdata_nxt[TW-1:0] = buf_b;
        `OFS_COMPARE_A: rdata_nxt[TW-1:0] = cmp_a;
        `OFS_COMPARE_B: rdata_nxt[TW-1:0] = cmp_b;
        `OFS_IRQ_STATUS: rdata_nxt[`IRQ_WIDTH-1:0] = sts_r;
        `OFS_IRQ_MASK: rdata_nxt[`IRQ_WIDTH-1:0] = mask_r;
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // register bank
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_r <= `CTL_RESET;
      sts_r <= '0;
      mask_r <= `IRQ_MASK_RESET;
      prdata <= 32'h0000_0000;
    end else begin
      ctl_r <= ctl_nxt;
      sts_r <= sts_nxt;
      mask_r <= mask_nxt;
      prdata <= rdata_nxt;
    end
  end

  // compare A channel
  delay_compare_unit #(
    .TW(TW)
  ) u_cmp_a (
    .pclk(pclk),
    .presetn(presetn),
    .buf_we(wr_acc && paddr == `OFS_BUFFER_A),
    .buf_wdata(pwdata[TW-1:0]),
    .xfer(xfer),
    .active(active),
    .comp_mode(comp_mode),
    .count_down(count_down),
    .timer_count(timer_count),
    .deadtime_adjusted_limit(deadtime_adjusted_limit),
    .up_en(ctl_r[`CTL_UP_A_BIT]),
    .dn_en(ctl_r[`CTL_DN_A_BIT] && comp_mode),
    .buf_q(buf_a),
    .cmp_q(cmp_a),
    .req(req_a)
  );

  // compare B channel
  delay_compare_unit #(
    .TW(TW)
  ) u_cmp_b (
    .pclk(pclk),
    .presetn(presetn),
    .buf_we(wr_acc && paddr == `OFS_BUFFER_B),
    .buf_wdata(pwdata[TW-1:0]),
    .xfer(xfer),
    .active(active),
    .comp_mode(comp_mode),
    .count_down(count_down),
    .timer_count(timer_count),
    .deadtime_adjusted_limit(deadtime_adjusted_limit),
    .up_en(ctl_r[`CTL_UP_B_BIT]),
    .dn_en(ctl_r[`CTL_DN_B_BIT] && comp_mode),
    .buf_q(buf_b),
    .cmp_q(cmp_b),
    .req(req_b)
  );

  // requests straight from the unit flip-flops
  assign adc_start_request_a = req_a;
  assign adc_start_request_b = req_b;
  assign adc_start_request_a_or_b = req_a | req_b;

  // feed the frame sync stage
  assign link.req_a = req_a;
  assign link.req_b = req_b;
  assign link.cycle_end = cycle_end;
  assign link.fs_enable = ctl_r[`CTL_FS_EN_BIT];
  assign link.fs_source = ctl_r[`CTL_FS_SRC_MSB:`CTL_FS_SRC_LSB];

  frame_sync_stage u_fsync (
    .pclk(pclk),
    .presetn(presetn),
    .link(link),
    .frame_sync_pin(frame_sync_pin)
  );

  // level interrupt while any unmasked status bit stands
  assign irq = |(sts_r & mask_r);
endmodule : adc_trigger_delay_compare

// ===== adc_trig_asserts.sv
// port-level assertions for the trigger block
`timescale 1ns/100ps
module adc_trig_asserts #(
  parameter int TW = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire adc_trig_pkg::mode_t timer_mode,
  input wire logic [TW-1:0] timer_count,
  input wire logic count_down,
  input wire logic [TW-1:0] deadtime_adjusted_limit,
  input wire logic cycle_end,
  input wire logic adc_start_request_a,
  input wire logic adc_start_request_b,
  input wire logic adc_start_request_a_or_b,
  input wire logic frame_sync_pin
);
  import adc_trig_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic comp_q;
  logic win_q;
  // last cycle's window, since a request lands one edge after its match
  always_ff @(posedge pclk) begin
    comp_q <= timer_mode inside {MODE_COMP1, MODE_COMP2, MODE_COMP3};
    win_q <= count_down ? (timer_count != 0 && timer_count <= deadtime_adjusted_limit)
                        : (timer_count < deadtime_adjusted_limit);
  end
  property p_or; adc_start_request_a_or_b == (adc_start_request_a || adc_start_request_b);
  endproperty
  a_or: assert property (p_or) else $error("combined request wrong");
  property p_one_a; adc_start_request_a |=> !adc_start_request_a; endproperty
  a_one_a: assert property (p_one_a) else $error("request a too long");
  property p_one_b; adc_start_request_b |=> !adc_start_request_b; endproperty
  a_one_b: assert property (p_one_b) else $error("request b too long");
  property p_mode; $past(timer_mode) inside {MODE_OTHER_A, MODE_OTHER_B}
    |-> !adc_start_request_a && !adc_start_request_b; endproperty
  a_mode: assert property (p_mode) else $error("request in unsupported mode");
  property p_win; (adc_start_request_a || adc_start_request_b) && comp_q |-> win_q; endproperty
  a_win: assert property (p_win) else $error("request outside count window");
  property p_fs_up; $rose(frame_sync_pin) |-> $past(adc_start_request_a_or_b); endproperty
  a_fs_up: assert property (p_fs_up) else $error("frame sync rose without request");
  property p_fs_dn; cycle_end && !adc_start_request_a_or_b |=> !frame_sync_pin; endproperty
  a_fs_dn: assert property (p_fs_dn) else $error("frame sync held past cycle end");
  property p_err; pslverr |-> psel && penable; endproperty
  a_err: assert property (p_err) else $error("error outside access phase");
  property p_rdy; psel && penable |-> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("access not answered");
endmodule : adc_trig_asserts

bind adc_trigger_delay_compare adc_trig_asserts #(.TW(TW)) chk_i (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .timer_mode(timer_mode), .timer_count(timer_count), .count_down(count_down),
  .deadtime_adjusted_limit(deadtime_adjusted_limit), .cycle_end(cycle_end),
  .adc_start_request_a(adc_start_request_a), .adc_start_request_b(adc_start_request_b),
  .adc_start_request_a_or_b(adc_start_request_a_or_b), .frame_sync_pin(frame_sync_pin));

// ===== adc_model.sv
// converter stand-in that counts start pulses
`timescale 1ns/100ps
module adc_model (
  input wire logic pclk,
  input wire logic clr,
  input wire logic start_a,
  input wire logic start_b,
  output logic [7:0] cnt_a,
  output logic [7:0] cnt_b
);
  // one conversion per sampled high; a stuck level would overcount
  always_ff @(posedge pclk) begin
    cnt_a <= clr ? 8'h00 : cnt_a + {7'h00, start_a === 1'h1};
    cnt_b <= clr ? 8'h00 : cnt_b + {7'h00, start_b === 1'h1};
  end
endmodule : adc_model

// ===== tb_top.sv
// self-checking bench for the trigger block
`timescale 1ns/100ps
`include "adc_trig_regs.svh"
module tb_top;
  import adc_trig_pkg::*;
  localparam logic [31:0] UA = 32'h0000_0010;
  localparam logic [31:0] DA = 32'h0000_0020;
  localparam logic [31:0] UB = 32'h0000_0040;
  localparam logic [31:0] DB = 32'h0000_0080;
  localparam logic [31:0] FE = 32'h0000_0100;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, err, count_down = 1'h0, count_crest = 1'h0, count_trough = 1'h0;
  logic ga_match = 1'h0, gd_write = 1'h0, cycle_end = 1'h0, clr = 1'h0;
  logic req_a, req_b, req_ab, fs_pin, irq;
  mode_t timer_mode = MODE_COMP1;
  logic [15:0] timer_count = 16'h00ff, lim = 16'h0008;
  logic [7:0] cnt_a, cnt_b;
  logic [4:0] src [3] = '{`FS_SRC_A, `FS_SRC_B, `FS_SRC_AB};
  int num_errors = 0, checked = 0;
  always #20 pclk = ~pclk;
  adc_trigger_delay_compare #(.TW(16), .CHANNEL(4)) uut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_mode(timer_mode),
    .timer_count(timer_count), .count_down(count_down), .deadtime_adjusted_limit(lim),
    .count_crest(count_crest), .count_trough(count_trough),
    .general_compare_a_match(ga_match), .general_compare_d_write(gd_write),
    .cycle_end(cycle_end), .adc_start_request_a(req_a), .adc_start_request_b(req_b),
    .adc_start_request_a_or_b(req_ab), .frame_sync_pin(fs_pin), .irq(irq));
  adc_model adc (.pclk(pclk), .clr(clr), .start_a(req_a), .start_b(req_b),
    .cnt_a(cnt_a), .cnt_b(cnt_b));
  task wrap_up;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer; answer taken at the rising edge that sees pready high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    // sampled before this edge's updates land, so these are the access values
    rd = prdata;
    err = pslverr;
    if (pready !== 1'h1) begin
      num_errors++;
      wrap_up();
    end
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task pulse(input int s);
    @(posedge pclk);
    case (s)
      0: count_trough <= 1'h1;
      1: ga_match <= 1'h1;
      2: gd_write <= 1'h1;
      3: cycle_end <= 1'h1;
      4: count_crest <= 1'h1;
      default: clr <= 1'h1;
    endcase
    @(posedge pclk);
    {count_crest, count_trough, ga_match, gd_write, cycle_end, clr} <= 6'h00;
  endtask : pulse
  // count ramp, then park the count clear of both compares
  task sweep(input logic [15:0] lo, input logic [15:0] hi, input logic dn);
    for (int k = 0; k <= hi - lo; k++) begin
      @(posedge pclk);
      timer_count <= dn ? hi - k[15:0] : lo + k[15:0];
      count_down <= dn;
    end
    @(posedge pclk);
    timer_count <= 16'h00ff;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
  endtask : sweep
  task t_reset;
    apb(1'h0, `OFS_REQUEST_CONTROL, 32'h0000_0000);
    chk(rd, `CTL_RESET);
    apb(1'h0, `OFS_IRQ_MASK, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'h0, 12'h0fc, 32'h0000_0000);
    chk(err, 1'h1);
    $display("test reset done");
  endtask : t_reset
  task t_comp;
    apb(1'h1, `OFS_IRQ_MASK, 32'h0000_0001);
    apb(1'h1, `OFS_BUFFER_A, 32'h0000_0002);
    apb(1'h1, `OFS_BUFFER_B, 32'h0000_0008);
    apb(1'h1, `OFS_REQUEST_CONTROL, `XFER_TROUGH | UA | DB);
    pulse(4);
    apb(1'h0, `OFS_COMPARE_A, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    pulse(0);
    apb(1'h0, `OFS_COMPARE_A, 32'h0000_0000);
    chk(rd, 32'h0000_0002);
    apb(1'h0, `OFS_COMPARE_B, 32'h0000_0000);
    chk(rd, 32'h0000_0008);
    pulse(5);
    sweep(16'h0000, 16'h0008, 1'h0);
    sweep(16'h0001, 16'h0008, 1'h1);
    chk(cnt_a, 8'h01);
    chk(cnt_b, 8'h01);
    chk(irq, 1'h1);
    apb(1'h0, `OFS_IRQ_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0007);
    @(negedge pclk);
    chk(irq, 1'h0);
    apb(1'h1, `OFS_IRQ_MASK, 32'h0000_0000);
    apb(1'h1, `OFS_REQUEST_CONTROL, `XFER_TROUGH | DA | UB);
    pulse(5);
    sweep(16'h0000, 16'h0008, 1'h0);
    sweep(16'h0001, 16'h0008, 1'h1);
    chk(cnt_a, 8'h01);
    chk(cnt_b, 8'h00);
    chk(irq, 1'h0);
    $display("test complementary done");
  endtask : t_comp
  task t_other;
    @(posedge pclk);
    timer_mode <= MODE_NORMAL;
    apb(1'h1, `OFS_BUFFER_A, 32'h0000_0005);
    apb(1'h1, `OFS_REQUEST_CONTROL, `XFER_TROUGH | UA);
    pulse(0);
    pulse(1);
    apb(1'h0, `OFS_COMPARE_A, 32'h0000_0000);
    chk(rd, 32'h0000_0002);
    apb(1'h1, `OFS_REQUEST_CONTROL, `XFER_CREST | UA);
    pulse(0);
    apb(1'h0, `OFS_COMPARE_A, 32'h0000_0000);
    chk(rd, 32'h0000_0002);
    pulse(1);
    apb(1'h0, `OFS_COMPARE_A, 32'h0000_0000);
    chk(rd, 32'h0000_0005);
    pulse(5);
    sweep(16'h0000, 16'h0008, 1'h1);
    chk(cnt_a, 8'h01);
    @(posedge pclk);
    timer_mode <= MODE_OTHER_A;
    pulse(5);
    sweep(16'h0000, 16'h0008, 1'h0);
    chk(cnt_a, 8'h00);
    @(posedge pclk);
    timer_mode <= MODE_COMP2;
    apb(1'h1, `OFS_BUFFER_A, 32'h0000_0003);
    apb(1'h1, `OFS_REQUEST_CONTROL, `XFER_NONE | UA | DB);
    pulse(2);
    apb(1'h0, `OFS_COMPARE_A, 32'h0000_0000);
    chk(rd, 32'h0000_0003);
    // crest and both codes in complementary mode
    apb(1'h1, `OFS_BUFFER_A, 32'h0000_0004);
    apb(1'h1, `OFS_REQUEST_CONTROL, `XFER_BOTH | UA);
    pulse(4);
    apb(1'h0, `OFS_COMPARE_A, 32'h0000_0000);
    chk(rd, 32'h0000_0004);
    apb(1'h1, `OFS_BUFFER_A, 32'h0000_0006);
    pulse(0);
    apb(1'h0, `OFS_COMPARE_A, 32'h0000_0000);
    chk(rd, 32'h0000_0006);
    apb(1'h1, `OFS_REQUEST_CONTROL, `XFER_CREST | UA);
    apb(1'h1, `OFS_BUFFER_A, 32'h0000_0007);
    pulse(0);
    apb(1'h0, `OFS_COMPARE_A, 32'h0000_0000);
    chk(rd, 32'h0000_0006);
    pulse(4);
    apb(1'h0, `OFS_COMPARE_A, 32'h0000_0000);
    chk(rd, 32'h0000_0007);
    $display("test modes done");
  endtask : t_other
  task t_fsync;
    timer_mode <= MODE_COMP3;
    for (int i = 0; i < 3; i++) begin
      apb(1'h1, `OFS_REQUEST_CONTROL, UA | DB | FE | {15'h0000, src[i], 12'h000});
      pulse(3);
      sweep(16'h0000, 16'h0008, 1'h0);
      chk(fs_pin, i != 1);
      sweep(16'h0001, 16'h0008, 1'h1);
      chk(fs_pin, 1'h1);
    end
    pulse(3);
    @(negedge pclk);
    chk(fs_pin, 1'h0);
    $display("test frame sync done");
  endtask : t_fsync
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    t_reset();
    t_comp();
    t_other();
    t_fsync();
    wrap_up();
  end
endmodule : tb_top
